// File: pkg/csw_params.svh
/*
  named constants for the clock sources and timewheels block.
  assumes inclusion by bare name; definitions only.
*/
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH
`define CSW_CLK_MHZ 100
`define CSW_CLK_KHZ 100000
`define CSW_FAST_KHZ 100
`define CSW_SLOW_DIV 100
`define CSW_THIRD_DIV 3
`define CSW_LOCK_US 250
`define CSW_PLL_MIN_KHZ 17'h0_5DC0
`define CSW_PLL_MAX_KHZ 17'h0_C350
`define CSW_A_IMO 5'h0_0
`define CSW_A_DBL 5'h0_1
`define CSW_A_PLL 5'h0_2
`define CSW_A_DIV 5'h0_3
`define CSW_A_STAT 5'h0_4
`define CSW_A_CTW 5'h0_5
`define CSW_A_CTWCNT 5'h0_6
`define CSW_A_FTW 5'h0_7
`define CSW_A_FTWCNT 5'h0_8
`define CSW_A_TRIM0 5'h1_0
`define CSW_N_RANGE 6
`define CSW_RST_RANGE 3'h0
`define CSW_RST_TRIM 8'h8_0
`define CSW_RST_TAP 4'h0
`define CSW_RST_TERM 5'h1_F
`define CSW_B_EN 0
`define CSW_B_SRC 1
`define CSW_B_SYS 3
`define CSW_B_CLR 0
`define CSW_B_CIE 1
`define CSW_B_WKE 2
`define CSW_B_TAP 4
`define CSW_B_FIE 8
`define CSW_B_FEN 9
`define CSW_B_FB 8
`endif

// File: pkg/csw_pkg.sv
/*
  types for the clock sources and timewheels block.
  assumes csw_params.svh supplies the constants.
*/
package csw_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } csw_bus_s;
  typedef enum logic [1:0] {
    CSW_SRC_IMO = 2'h0,
    CSW_SRC_ECO = 2'h1,
    CSW_SRC_DSI = 2'h2
  } csw_src_e;
  typedef enum logic [2:0] {
    CSW_PLL_OFF = 3'h1,
    CSW_PLL_ACQ = 3'h2,
    CSW_PLL_LOCK = 3'h4
  } csw_pll_e;
endpackage

// File: hw/csw_clk_ctrl.sv
/*
  clock source selection, pll lock tracking and timewheels,
  all on one 100 MHz clock; slow rates are enable pulses.
  assumes oscillator frequencies arrive as kHz numbers and
  that the register master follows the plain strobe port.
*/
`timescale 1ns/100ps
`include "csw_params.svh"

module csw_clk_ctrl #(
  parameter int LOCK_CYC = `CSW_LOCK_US * `CSW_CLK_MHZ,
  parameter int FAST_DIV = `CSW_CLK_KHZ / `CSW_FAST_KHZ,
  parameter int CTW_W = 13,
  parameter int FTW_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input csw_pkg::csw_bus_s bus,
  output logic [15:0] rdata,
  input wire logic [16:0] eco_khz,
  input wire logic [16:0] dsi_khz,
  input wire logic hibernate,
  input wire logic debug_halt,
  output logic [16:0] imo_khz,
  output logic [7:0] imo_trim,
  output logic [16:0] dbl_khz,
  output logic [16:0] pll_khz,
  output logic [16:0] sys_khz,
  output logic pll_lock,
  output logic lock_dsi,
  output logic tick_100k,
  output logic tick_33k,
  output logic tick_1k,
  output logic ctw_irq,
  output logic ctw_wake,
  output logic ftw_irq
);
  import csw_pkg::*;

  function automatic logic [16:0] range_khz(input logic [2:0] r);
    case (r)
      3'h0: range_khz = 17'h0_0BB8;
      3'h1: range_khz = 17'h0_1770;
      3'h2: range_khz = 17'h0_2EE0;
      3'h3: range_khz = 17'h0_5DC0;
      3'h4: range_khz = 17'h0_BB80;
      default: range_khz = 17'h0_F230;
    endcase
  endfunction

  function automatic logic [16:0] pick(input logic [1:0] s,
      input logic [16:0] main_internal_oscillator, input logic [16:0] crystal_oscillator_clock,
      input logic [16:0] dsi);
    case (s)
      CSW_SRC_ECO: pick = crystal_oscillator_clock;
      CSW_SRC_DSI: pick = dsi;
      default: pick = main_internal_oscillator;
    endcase
  endfunction

  logic [2:0] range_r;
  logic [7:0] trim_r [`CSW_N_RANGE];
  logic dbl_en_r;
  logic [1:0] dbl_src_r;
  logic pll_en_r;
  logic [1:0] pll_src_r;
  logic pll_sys_r;
  logic [5:0] in_div_r;
  logic [5:0] fb_div_r;
  logic ctw_ie_r;
  logic ctw_we_r;
  logic [3:0] tap_r;
  logic [FTW_W-1:0] term_r;
  logic ftw_ie_r;
  logic ftw_en_r;
  logic [CTW_W-1:0] ctw_r;
  logic [FTW_W-1:0] ftw_r;
  logic [9:0] fast_div_r;
  logic [6:0] slow_div_r;
  logic [1:0] third_div_r;
  logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_r;
  csw_pll_e pll_st_r;
  logic [16:0] ref_khz;
  logic [16:0] dbl_ref;
  logic [2:0] trim_sel;
  logic [6:0] in_n;
  logic [6:0] fb_n;
  logic [23:0] prod;
  logic [23:0] quot;
  logic in_band;
  logic pll_touch;
  logic ctw_clr;
  logic ctw_step;
  logic [CTW_W-1:0] ctw_inc;
  logic [CTW_W-1:0] tap_mask;
  logic fast_hit;

  assign ctw_clr = bus.we && bus.addr == `CSW_A_CTW && bus.wdata[`CSW_B_CLR];
  assign pll_touch = bus.we && (bus.addr == `CSW_A_PLL || bus.addr == `CSW_A_DIV);

  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      range_r <= `CSW_RST_RANGE;
      dbl_en_r <= 1'b0;
      dbl_src_r <= CSW_SRC_IMO;
      pll_en_r <= 1'b0;
      pll_src_r <= CSW_SRC_IMO;
      pll_sys_r <= 1'b0;
      in_div_r <= 6'h0_0;
      fb_div_r <= 6'h0_0;
      ctw_ie_r <= 1'b0;
      ctw_we_r <= 1'b0;
      tap_r <= `CSW_RST_TAP;
      term_r <= FTW_W'(`CSW_RST_TERM);
      ftw_ie_r <= 1'b0;
      ftw_en_r <= 1'b0;
    end else if (bus.we) begin
      case (bus.addr)
        `CSW_A_IMO: begin
          range_r <= bus.wdata[2:0];
        end
        `CSW_A_DBL: begin
          dbl_en_r <= bus.wdata[`CSW_B_EN];
          dbl_src_r <= bus.wdata[`CSW_B_SRC+:2];
        end
        `CSW_A_PLL: begin
          pll_en_r <= bus.wdata[`CSW_B_EN];
          pll_src_r <= bus.wdata[`CSW_B_SRC+:2];
          pll_sys_r <= bus.wdata[`CSW_B_SYS];
        end
        `CSW_A_DIV: begin
          in_div_r <= bus.wdata[5:0];
          fb_div_r <= bus.wdata[`CSW_B_FB+:6];
        end
        `CSW_A_CTW: begin
          ctw_ie_r <= bus.wdata[`CSW_B_CIE];
          ctw_we_r <= bus.wdata[`CSW_B_WKE];
          tap_r <= bus.wdata[`CSW_B_TAP+:4];
        end
        `CSW_A_FTW: begin
          term_r <= bus.wdata[FTW_W-1:0];
          ftw_ie_r <= bus.wdata[`CSW_B_FIE];
          ftw_en_r <= bus.wdata[`CSW_B_FEN];
        end
        default: begin
        end
      endcase
    end
  end

  // one trim byte per range; the applied trim follows the range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CSW_N_RANGE; i++) begin
        trim_r[i] <= `CSW_RST_TRIM;
      end
    end else if (bus.we) begin
      for (int i = 0; i < `CSW_N_RANGE; i++) begin
        if (bus.addr == 5'(`CSW_A_TRIM0 + i)) begin
          trim_r[i] <= bus.wdata[7:0];
        end
      end
    end
  end

  // pll ratio: input divider 1..64, feedback divider 2..64
  assign in_n = {1'b0, in_div_r} + 7'h0_1;
  assign fb_n = (fb_div_r == 6'h0_0) ? 7'h0_2 : {1'b0, fb_div_r} + 7'h0_1;
  assign ref_khz = pick(pll_src_r, imo_khz, eco_khz, dsi_khz);
  // a function result cannot be sliced, so the doubler source gets its own net
  assign dbl_ref = pick(dbl_src_r, imo_khz, eco_khz, dsi_khz);
  // the two spare range codes run at the top frequency, so they share its trim
  assign trim_sel = (range_r > 3'(`CSW_N_RANGE - 1)) ? 3'(`CSW_N_RANGE - 1) : range_r;
  assign prod = {7'h0_0, ref_khz} * {17'h0_0000, fb_n};
  assign quot = prod / {17'h0_0000, in_n};
  // a ratio outside the band never locks, so it never drives the system
  assign in_band = quot >= {7'h0_0, `CSW_PLL_MIN_KHZ} &&
                   quot <= {7'h0_0, `CSW_PLL_MAX_KHZ};

  // frequency outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imo_khz <= 17'h0_0000;
      imo_trim <= `CSW_RST_TRIM;
      dbl_khz <= 17'h0_0000;
      pll_khz <= 17'h0_0000;
      sys_khz <= 17'h0_0000;
    end else begin
      imo_khz <= range_khz(range_r);
      imo_trim <= trim_r[trim_sel];
      // doubler accepts any input up to 65535 kHz, since bit 16 of the source is dropped; 24 MHz gives the 48 MHz usb clock
      dbl_khz <= dbl_en_r ? {dbl_ref[15:0], 1'b0} : 17'h0_0000;
      pll_khz <= (pll_en_r && in_band) ? quot[16:0] : 17'h0_0000;
      if (!pll_sys_r) begin
        sys_khz <= imo_khz;
      end else if (pll_st_r == CSW_PLL_LOCK) begin
        sys_khz <= pll_khz;
      end else begin
        sys_khz <= ref_khz;
      end
    end
  end

  // lock tracking; any write to the pll setup restarts acquisition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_st_r <= CSW_PLL_OFF;
      lock_cnt_r <= '0;
    end else if (pll_touch || !pll_en_r) begin
      pll_st_r <= CSW_PLL_OFF;
      lock_cnt_r <= '0;
    end else begin
      case (pll_st_r)
        CSW_PLL_OFF: begin
          pll_st_r <= CSW_PLL_ACQ;
        end
        CSW_PLL_ACQ: begin
          if (lock_cnt_r >= ($bits(lock_cnt_r))'(LOCK_CYC - 2)) begin
            if (in_band) begin
              pll_st_r <= CSW_PLL_LOCK;
            end
          end else begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
          end
        end
        CSW_PLL_LOCK: begin
          pll_st_r <= CSW_PLL_LOCK;
        end
        default: begin
          pll_st_r <= CSW_PLL_OFF;
        end
      endcase
    end
  end

  assign pll_lock = pll_st_r == CSW_PLL_LOCK;
  // firmware must stop the pll before low power; nothing here forces it
  assign lock_dsi = pll_lock;

  // low-speed ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_div_r <= 10'h0_00;
      slow_div_r <= 7'h0_0;
      third_div_r <= 2'h0;
      tick_100k <= 1'b0;
      tick_33k <= 1'b0;
      tick_1k <= 1'b0;
    end else begin
      tick_100k <= fast_hit;
      tick_33k <= 1'b0;
      tick_1k <= 1'b0;
      if (fast_hit) begin
        fast_div_r <= 10'h0_00;
        if (third_div_r == 2'(`CSW_THIRD_DIV - 1)) begin
          third_div_r <= 2'h0;
          tick_33k <= 1'b1;
        end else begin
          third_div_r <= third_div_r + 2'h1;
        end
        if (slow_div_r == 7'(`CSW_SLOW_DIV - 1)) begin
          slow_div_r <= 7'h0_0;
          tick_1k <= 1'b1;
        end else begin
          slow_div_r <= slow_div_r + 7'h0_1;
        end
      end else begin
        fast_div_r <= fast_div_r + 10'h0_01;
      end
    end
  end

  assign fast_hit = fast_div_r == 10'(FAST_DIV - 1);

  // central counter; a clear in the same cycle as a step wins
  assign ctw_step = tick_1k && !hibernate && !debug_halt;
  assign ctw_inc = ctw_r + 1'b1;
  assign tap_mask = CTW_W'((32'h0000_0002 << tap_r) - 32'h0000_0001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctw_r <= '0;
      ctw_irq <= 1'b0;
      ctw_wake <= 1'b0;
    end else begin
      ctw_irq <= 1'b0;
      ctw_wake <= 1'b0;
      if (ctw_clr) begin
        ctw_r <= '0;
      end else if (ctw_step) begin
        ctw_r <= ctw_inc;
        // period is two to the power tap plus one milliseconds for taps up to 12; larger taps give 8192
        if ((ctw_inc & tap_mask) == '0) begin
          ctw_irq <= ctw_ie_r;
          ctw_wake <= ctw_we_r;
        end
      end
    end
  end

  // fast counter restarts after the terminal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ftw_r <= '0;
      ftw_irq <= 1'b0;
    end else begin
      ftw_irq <= 1'b0;
      if (!ftw_en_r) begin
        ftw_r <= '0;
      end else if (tick_100k) begin
        if (ftw_r == term_r) begin
          ftw_r <= '0;
          ftw_irq <= ftw_ie_r;
        end else begin
          ftw_r <= ftw_r + 1'b1;
        end
      end
    end
  end

  // read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (!bus.re) begin
      rdata <= 16'h0000;
    end else begin
      case (bus.addr)
        `CSW_A_IMO: rdata <= {13'h0000, range_r};
        `CSW_A_DBL: rdata <= {13'h0000, dbl_src_r, dbl_en_r};
        `CSW_A_PLL: rdata <= {12'h000, pll_sys_r, pll_src_r, pll_en_r};
        `CSW_A_DIV: rdata <= {2'h0, fb_div_r, 2'h0, in_div_r};
        `CSW_A_STAT: rdata <= {15'h0000, pll_lock};
        `CSW_A_CTW: rdata <= {8'h00, tap_r, 1'b0, ctw_we_r, ctw_ie_r, 1'b0};
        `CSW_A_CTWCNT: rdata <= 16'(ctw_r);
        `CSW_A_FTW: rdata <= 16'({ftw_en_r, ftw_ie_r, 3'h0, term_r});
        `CSW_A_FTWCNT: rdata <= 16'(ftw_r);
        default: begin
          rdata <= 16'h0000;
          for (int i = 0; i < `CSW_N_RANGE; i++) begin
            if (bus.addr == 5'(`CSW_A_TRIM0 + i)) begin
              rdata <= {8'h00, trim_r[i]};
            end
          end
        end
      endcase
    end
  end
endmodule

// File: bench/csw_clk_ctrl_asserts.sv
/* port-level checks for csw_clk_ctrl.
   assumes a bind from the bench top and a tick divider of 4. */
`timescale 1ns/100ps
module csw_clk_ctrl_chk #(
  parameter int LOCK_CYC = 20,
  parameter int FAST_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input csw_pkg::csw_bus_s bus,
  input wire logic [15:0] rdata,
  input wire logic [16:0] eco_khz,
  input wire logic [16:0] dsi_khz,
  input wire logic hibernate,
  input wire logic debug_halt,
  input wire logic [16:0] imo_khz,
  input wire logic [7:0] imo_trim,
  input wire logic [16:0] dbl_khz,
  input wire logic [16:0] pll_khz,
  input wire logic [16:0] sys_khz,
  input wire logic pll_lock,
  input wire logic lock_dsi,
  input wire logic tick_100k,
  input wire logic tick_33k,
  input wire logic tick_1k,
  input wire logic ctw_irq,
  input wire logic ctw_wake,
  input wire logic ftw_irq
);
  import csw_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_lock_copy: assert property (lock_dsi == pll_lock)
    else $error("routed lock differs from status");
  a_lock_drop: assert property (
    bus.we && bus.addr inside {5'h02, 5'h03} |=> !pll_lock) else $error("lock kept after write");
  a_lock_hold: assert property (
    pll_lock && !(bus.we && bus.addr inside {5'h02, 5'h03}) |=> pll_lock)
    else $error("lock lost without cause");
  a_third_sub: assert property (tick_33k |-> tick_100k)
    else $error("third-rate tick off the fast tick");
  a_slow_sub: assert property (tick_1k |-> tick_100k)
    else $error("slow tick off the fast tick");
  // spacing is fixed at the bench divider of 4
  a_fast_space: assert property (tick_100k |=> !tick_100k [*3] ##1 tick_100k)
    else $error("fast tick spacing wrong");
  a_ftw_cause: assert property (ftw_irq |-> $past(tick_100k))
    else $error("fast irq without tick");
  a_ctw_cause: assert property (ctw_irq || ctw_wake |-> $past(tick_1k))
    else $error("central event without tick");
  a_irq_single: assert property (ftw_irq || ctw_irq |=> !ftw_irq && !ctw_irq)
    else $error("irq longer than one cycle");
  a_rdata_idle: assert property (!$past(bus.re) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule

// File: bench/csw_irq_sink.sv
/* interrupt and tick consumer: counts one-cycle events.
   assumes clr is a level from the bench that zeroes all counts. */
`timescale 1ns/100ps
module csw_irq_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic ftw_irq,
  input wire logic ctw_irq,
  input wire logic ctw_wake,
  input wire logic tick_33k,
  output logic [15:0] n_ftw,
  output logic [15:0] n_ctw,
  output logic [15:0] n_wake,
  output logic [15:0] n_t33
);
  // counts per cycle, so a stretched pulse shows as extra events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n || clr) begin
      n_ftw <= '0;
      n_ctw <= '0;
      n_wake <= '0;
      n_t33 <= '0;
    end else begin
      n_ftw <= n_ftw + 16'(ftw_irq);
      n_ctw <= n_ctw + 16'(ctw_irq);
      n_wake <= n_wake + 16'(ctw_wake);
      n_t33 <= n_t33 + 16'(tick_33k);
    end
  end
endmodule

// File: bench/tb_clock_sources_and_timewheels.sv
/* self-checking bench for csw_clk_ctrl.
   assumes short counts: lock 20 cycles, fast tick every 4 cycles. */
`timescale 1ns/100ps
`include "csw_params.svh"
module tb_clock_sources_and_timewheels;
  import csw_pkg::*;
  localparam int LOCK_CYC = 20;
  logic clk = 0, rst_n = 0, hibernate = 0, debug_halt = 0, clr = 0;
  csw_bus_s bus = '0;
  logic [16:0] eco_khz = 17'h0_2EE0, dsi_khz = 17'h0_2710;
  logic [15:0] rdata, rv, c0, n_ftw, n_ctw, n_wake, n_t33;
  logic [16:0] imo_khz, dbl_khz, pll_khz, sys_khz;
  logic [7:0] imo_trim;
  logic pll_lock, lock_dsi, tick_100k, tick_33k, tick_1k, ctw_irq, ctw_wake, ftw_irq;
  logic [16:0] imo_tab [6] = '{17'h0_0BB8, 17'h0_1770, 17'h0_2EE0, 17'h0_5DC0,
    17'h0_BB80, 17'h0_F230};
  logic [16:0] dbl_tab [3] = '{17'h0_BB80, 17'h0_5DC0, 17'h0_4E20};
  int err_count = 0, checks_done = 0, cyc = 0;
  csw_clk_ctrl #(.LOCK_CYC(LOCK_CYC), .FAST_DIV(4)) dut (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .eco_khz(eco_khz), .dsi_khz(dsi_khz), .hibernate(hibernate),
    .debug_halt(debug_halt), .imo_khz(imo_khz), .imo_trim(imo_trim), .dbl_khz(dbl_khz),
    .pll_khz(pll_khz), .sys_khz(sys_khz), .pll_lock(pll_lock), .lock_dsi(lock_dsi),
    .tick_100k(tick_100k), .tick_33k(tick_33k), .tick_1k(tick_1k), .ctw_irq(ctw_irq),
    .ctw_wake(ctw_wake), .ftw_irq(ftw_irq));
  csw_irq_sink sink (.clk(clk), .rst_n(rst_n), .clr(clr), .ftw_irq(ftw_irq), .ctw_irq(ctw_irq),
    .ctw_wake(ctw_wake), .tick_33k(tick_33k), .n_ftw(n_ftw), .n_ctw(n_ctw), .n_wake(n_wake),
    .n_t33(n_t33));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk) bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk) bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge clk) bus.re <= 1'b0;
    @(negedge clk) rv = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic count_win(input int n);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    wait_cyc(n);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    wait_cyc(4);
    @(posedge clk) rst_n <= 1'b1;
    rd(5'h15);
    chk("trim_reset", 17'h0_0080, {1'b0, rv});
    rd(5'h1F);
    chk("unmapped", 17'h0_0000, {1'b0, rv});
    for (int r = 0; r < 6; r++) begin
      wr(5'h10 + 5'(r), 16'h0040 + 16'(r));
      wr(5'h00, 16'(r));
      wait_cyc(3);
      chk("imo_khz", imo_tab[r], imo_khz);
      chk("imo_trim", 17'h0_0040 + 17'(r), {9'h000, imo_trim});
    end
    wr(5'h00, 16'h0007);
    wait_cyc(3);
    chk("imo_khz_spare", 17'h0_F230, imo_khz);
    chk("imo_trim_spare", 17'h0_0045, {9'h000, imo_trim});
    wr(5'h00, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      wr(5'h01, 16'h0001 | 16'(i << 1));
      wait_cyc(3);
      chk("dbl_khz", dbl_tab[i], dbl_khz);
    end
    wr(5'h00, 16'h0000);
    wr(5'h03, 16'h0F00);
    wr(5'h02, 16'h0009);
    wait_cyc(LOCK_CYC - 2);
    chk("lock_early", 17'h0_0000, {16'h0000, pll_lock});
    chk("sys_unlocked", 17'h0_0BB8, sys_khz);
    wait_cyc(4);
    chk("lock_set", 17'h0_0001, {16'h0000, pll_lock});
    chk("pll_khz", 17'h0_BB80, pll_khz);
    chk("sys_locked", 17'h0_BB80, sys_khz);
    rd(5'h04);
    chk("lock_bit", 17'h0_0001, {1'b0, rv});
    wr(5'h03, 16'h0701);
    wr(5'h02, 16'h000B);
    wait_cyc(0);
    chk("lock_cleared", 17'h0_0000, {16'h0000, pll_lock});
    wait_cyc(LOCK_CYC + 2);
    chk("eco_ref_lock", 17'h0_0001, {16'h0000, lock_dsi});
    chk("eco_ref_khz", 17'h0_BB80, pll_khz);
    @(posedge clk) dsi_khz <= 17'h0_0FA0;
    wr(5'h02, 16'h000D);
    wait_cyc(LOCK_CYC + 4);
    chk("low_band_lock", 17'h0_0000, {16'h0000, pll_lock});
    chk("low_band_khz", 17'h0_0000, pll_khz);
    wr(5'h02, 16'h0000); // pll off before low power
    @(posedge clk) hibernate <= 1'b1;
    wr(5'h05, 16'h0007);
    wait_cyc(398);
    rd(5'h06);
    chk("ctw_clr_hib", 17'h0_0000, {1'b0, rv});
    @(posedge clk) {hibernate, debug_halt} <= 2'b01;
    wait_cyc(398);
    rd(5'h06);
    chk("ctw_halt", 17'h0_0000, {1'b0, rv});
    @(posedge clk) debug_halt <= 1'b0;
    rd(5'h06);
    c0 = rv;
    wait_cyc(398);
    rd(5'h06);
    chk("ctw_step", {1'b0, c0 + 16'h0001}, {1'b0, rv});
    count_win(1600);
    chk("ctw_irqs", 17'h0_0002, {1'b0, n_ctw});
    chk("ctw_wakes", 17'h0_0002, {1'b0, n_wake});
    // tap of one: one event every fourth step, wake disabled
    wr(5'h05, 16'h0012);
    count_win(1600);
    chk("ctw_irqs_tap", 17'h0_0001, {1'b0, n_ctw});
    chk("ctw_wakes_off", 17'h0_0000, {1'b0, n_wake});
    wr(5'h07, 16'h0303);
    count_win(96);
    chk("ftw_irqs", 17'h0_0006, {1'b0, n_ftw});
    chk("third_ticks", 17'h0_0008, {1'b0, n_t33});
    rd(5'h08);
    chk("ftw_in_term", 17'h0_0001, {16'h0000, rv <= 16'h0003});
    wr(5'h07, 16'h0203);
    count_win(96);
    chk("ftw_masked", 17'h0_0000, {1'b0, n_ftw});
    end_of_test;
  end
endmodule
bind csw_clk_ctrl csw_clk_ctrl_chk #(.LOCK_CYC(LOCK_CYC), .FAST_DIV(FAST_DIV)) u_chk (
  .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .eco_khz(eco_khz), .dsi_khz(dsi_khz),
  .hibernate(hibernate), .debug_halt(debug_halt), .imo_khz(imo_khz), .imo_trim(imo_trim),
  .dbl_khz(dbl_khz), .pll_khz(pll_khz), .sys_khz(sys_khz), .pll_lock(pll_lock),
  .lock_dsi(lock_dsi), .tick_100k(tick_100k), .tick_33k(tick_33k), .tick_1k(tick_1k),
  .ctw_irq(ctw_irq), .ctw_wake(ctw_wake), .ftw_irq(ftw_irq));
